// *** logic/dtd_datapath.sv ***

// Byte FIFO with registered flags on both sides
module dtd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  wire  [AW:0]      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  assign out_data = mem[rd_q];

  // Storage array has no reset
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and flags; flags come from flops so the source sees clean ready
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_q      <= '0;
      rd_q      <= '0;
      cnt_q     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_q      <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q      <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q     <= cnt_d;
      in_ready  <= cnt_d != (AW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end
endmodule

module dtd_datapath
  import dtd_pkg::*;
#(
  parameter bit  SUPPORT_PT = 1'b1,
  parameter bit  SUPPORT_PS = 1'b1,
  parameter int  PS_LEVELS  = 2,
  parameter int  MAX_FLOWS  = 1,
  parameter int  FIFO_DEPTH = 16,
  parameter logic [15:0] SYNC_GUARD = 16'h0010
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Session setup
  input  wire logic        setup_req,
  input  wire logic        setup_has_pt,
  input  wire logic        setup_has_ps,
  input  wire logic [3:0]  setup_levels,
  input  wire logic [3:0]  setup_flows,
  input  wire logic [5:0]  setup_dscp_hi,
  input  wire logic [5:0]  setup_dscp_lo,
  input  wire logic [15:0] setup_sync_interval,
  input  wire logic [47:0] setup_core_mac,
  output logic             setup_accept,
  output logic             setup_reject,
  output logic [1:0]       session_mode,
  // Timebase
  input  wire logic        ts_load,
  input  wire logic [31:0] ts_load_value,
  output logic [31:0]      ts_now,
  // Passthrough packet bytes
  input  wire logic        pt_valid,
  input  wire logic [7:0]  pt_data,
  input  wire logic        pt_sop,
  output logic             pt_ready,
  // Low-latency packet-stream receiver
  input  wire logic        ps_hi_valid,
  input  wire logic [7:0]  ps_hi_data,
  input  wire logic        ps_hi_last,
  output logic             ps_hi_ready,
  // Higher-latency packet-stream receiver
  input  wire logic        ps_lo_valid,
  input  wire logic [7:0]  ps_lo_data,
  input  wire logic        ps_lo_last,
  output logic             ps_lo_ready,
  // RF byte stream
  input  wire logic        rf_ready,
  output logic             rf_valid,
  output logic [7:0]       rf_data,
  output logic             rf_sop
);

  // Session and timing state
  dtd_mode_t    mode_q;
  logic [15:0]  interval_q;
  logic [47:0]  core_mac_q;
  logic [17:0]  acc_q;
  logic [31:0]  ts_q;
  logic [15:0]  elapsed_q;
  // Packet engine state
  dtd_kind_t    kind_q;
  logic [7:0]   pos_q;
  logic [3:0]   cc_q;
  logic         mid_frame_q;
  logic         frame_done_q;
  logic         sel_lo_q;
  logic         pt_pusi_q;
  logic         pt_b4_zero_q;
  logic         pt_sync_q;
  logic [31:0]  ts_hold_q;
  logic [15:0]  crc_q;

  // Queue drain side
  logic         pt_v;
  logic [8:0]   pt_head;
  logic         hi_v;
  logic [8:0]   hi_head;
  logic         lo_v;
  logic [8:0]   lo_head;
  logic         pt_pop;
  logic         hi_pop;
  logic         lo_pop;

  // Each receiver feeds its own queue; the passthrough path is a third
  dtd_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_pt_q (
    .mclk(mclk), .nrst(nrst),
    .in_valid(pt_valid), .in_data({pt_sop, pt_data}), .in_ready(pt_ready),
    .out_valid(pt_v), .out_data(pt_head), .out_ready(pt_pop)
  );
  dtd_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_hi_q (
    .mclk(mclk), .nrst(nrst),
    .in_valid(ps_hi_valid), .in_data({ps_hi_last, ps_hi_data}), .in_ready(ps_hi_ready),
    .out_valid(hi_v), .out_data(hi_head), .out_ready(hi_pop)
  );
  dtd_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_lo_q (
    .mclk(mclk), .nrst(nrst),
    .in_valid(ps_lo_valid), .in_data({ps_lo_last, ps_lo_data}), .in_ready(ps_lo_ready),
    .out_valid(lo_v), .out_data(lo_head), .out_ready(lo_pop)
  );

  // Session admission checks
  wire both_types = setup_has_pt && setup_has_ps;
  wire pt_ok  = SUPPORT_PT && setup_levels == 4'h1;
  wire ps_ok  = SUPPORT_PS && setup_levels >= 4'h2
                && setup_levels <= 4'(PS_LEVELS)
                && setup_dscp_hi != setup_dscp_lo;
  wire flows_ok = setup_flows != 4'h0 && setup_flows <= 4'(MAX_FLOWS);
  wire setup_ok = !both_types && flows_ok
                  && ((setup_has_pt && pt_ok) || (setup_has_ps && ps_ok));

  // Accepted setups replace the session; refused ones leave it alone
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_q       <= MODE_NONE;
      interval_q   <= '0;
      core_mac_q   <= '0;
      setup_accept <= 1'b0;
      setup_reject <= 1'b0;
    end else begin
      setup_accept <= setup_req && setup_ok;
      setup_reject <= setup_req && !setup_ok;
      if (setup_req && setup_ok) begin
        mode_q     <= setup_has_pt ? MODE_PT : MODE_PS;
        interval_q <= setup_sync_interval;
        core_mac_q <= setup_core_mac;
      end
    end
  end
  assign session_mode = mode_q;

  // Fractional divider gives the 10.24 MHz tick from the 250 MHz clock
  wire [17:0] acc_sum = acc_q + 18'(TB_KHZ);
  wire        tb_tick = acc_sum >= 18'(MCLK_KHZ);

  // Timestamp counter; loading from the external time keeps the lag at zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= '0;
      ts_q  <= '0;
    end else begin
      acc_q <= tb_tick ? 18'(acc_sum - 18'(MCLK_KHZ)) : acc_sum;
      if (ts_load) begin
        ts_q <= ts_load_value;
      end else if (tb_tick) begin
        ts_q <= ts_q + 32'h1;
      end
    end
  end
  assign ts_now = ts_q;

  // Byte handshake toward RF and the choice of packet kind at each start
  wire adv      = !rf_valid || rf_ready;
  wire at_start = pos_q == 8'h00;
  wire [16:0] due_sum = {1'b0, elapsed_q} + {1'b0, SYNC_GUARD};
  wire sync_due = mode_q == MODE_PS && due_sum >= {1'b0, interval_q};
  wire pt_skip  = mode_q == MODE_PT && pt_v && !pt_head[8];
  dtd_kind_t kind_new;
  always_comb begin
    kind_new = K_NULL;
    if (mode_q == MODE_PT && pt_v && pt_head[8]) begin
      kind_new = K_PT;
    end else if (mode_q == MODE_PS) begin
      if (sync_due && !mid_frame_q) begin
        kind_new = K_SYNC;
      end else if (mid_frame_q || hi_v || lo_v) begin
        kind_new = K_DATA;
      end
    end
  end
  dtd_kind_t cur_kind;
  assign cur_kind = at_start ? kind_new : kind_q;

  // Strict priority: the low-latency queue wins at each frame boundary
  wire sel_lo    = at_start && !mid_frame_q ? !hi_v : sel_lo_q;
  wire q_v       = sel_lo ? lo_v : hi_v;
  wire [8:0] q_h = sel_lo ? lo_head : hi_head;
  // Frame state cannot move before the pointer byte, so it decides the header directly
  wire data_pusi = !mid_frame_q;
  wire data_slot = (pos_q == POS_PTR && !data_pusi) || pos_q >= POS_MSG;

  // Header check sequence over the four header bytes
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Sync message bytes by packet position
  logic [7:0] sync_b;
  always_comb begin
    int k;
    k = 0;
    sync_b = STUFF_BYTE;
    if (pos_q == POS_MSG) begin
      sync_b = {FRAME_CONTROL_TYPE_MAC, FRAME_CONTROL_PARAMETER_TIMING, 1'b0};
    end else if (pos_q == POS_MSG + 8'h01) begin
      sync_b = SYNC_MAC_PARM;
    end else if (pos_q == POS_MSG + 8'h02) begin
      sync_b = SYNC_MAC_LEN[15:8];
    end else if (pos_q == POS_HDR_END) begin
      sync_b = SYNC_MAC_LEN[7:0];
    end else if (pos_q == POS_HCS0) begin
      sync_b = ~crc_q[7:0];
    end else if (pos_q == POS_HCS1) begin
      sync_b = ~crc_q[15:8];
    end else if (pos_q >= POS_DA && pos_q < POS_SA) begin
      k = 40 - 8 * int'(pos_q - POS_DA);
      sync_b = SYNC_DA[k +: 8];
    end else if (pos_q >= POS_SA && pos_q < POS_MLEN) begin
      k = 40 - 8 * int'(pos_q - POS_SA);
      sync_b = core_mac_q[k +: 8];
    end else if (pos_q == POS_MLEN) begin
      sync_b = SYNC_MSG_LEN[15:8];
    end else if (pos_q == POS_MLEN + 8'h01) begin
      sync_b = SYNC_MSG_LEN[7:0];
    end else if (pos_q == POS_DEST_ACCESS_POINT || pos_q == POS_DEST_ACCESS_POINT + 8'h01) begin
      sync_b = NULL_SAP;
    end else if (pos_q == POS_DEST_ACCESS_POINT + 8'h02) begin
      sync_b = LLC_UI;
    end else if (pos_q == POS_DEST_ACCESS_POINT + 8'h03) begin
      sync_b = SYNC_VERSION;
    end else if (pos_q == POS_DEST_ACCESS_POINT + 8'h04) begin
      sync_b = SYNC_TYPE;
    end else if (pos_q == POS_DEST_ACCESS_POINT + 8'h05) begin
      sync_b = SYNC_RSVD;
    end else if (pos_q >= POS_TS && pos_q <= POS_MSG_END) begin
      k = 24 - 8 * int'(pos_q - POS_TS);
      sync_b = ts_hold_q[k +: 8];
    end
  end

  // Timestamp byte that overwrites a passthrough sync
  wire in_ts   = pos_q >= POS_TS && pos_q <= POS_MSG_END;
  wire [4:0] ts_sh = 5'(8'h18 - ((pos_q - POS_TS) << 3));
  wire [7:0] ts_b  = 8'(ts_hold_q >> ts_sh);
  wire pt_sync_now = pos_q == POS_MSG && pt_pusi_q && pt_b4_zero_q
                     && pt_head[7:0] == PT_SYNC_B5;

  // Byte produced for the current position, and whether it is ready
  logic [7:0] byte_d;
  logic       have;
  always_comb begin
    byte_d = STUFF_BYTE;
    have   = 1'b1;
    if (pos_q == 8'h00 && cur_kind != K_PT) begin
      byte_d = TS_BYTE;
      have   = !pt_skip;
    end else begin
      case (cur_kind)
        K_NULL: begin
          if (pos_q == POS_PID_HI) begin
            byte_d = {3'b000, PID_NULL[12:8]};
          end else if (pos_q == POS_PID_LO) begin
            byte_d = PID_NULL[7:0];
          end else if (pos_q == POS_CC) begin
            byte_d = {AFC_PAYLOAD, 4'h0};
          end
        end
        K_PT: begin
          have   = pt_v;
          byte_d = (pt_sync_q && in_ts) ? ts_b : pt_head[7:0];
        end
        K_SYNC, K_DATA: begin
          if (pos_q == POS_PID_HI) begin
            byte_d = {1'b0, cur_kind == K_SYNC || data_pusi, 1'b0, PID_MAC[12:8]};
          end else if (pos_q == POS_PID_LO) begin
            byte_d = PID_MAC[7:0];
          end else if (pos_q == POS_CC) begin
            byte_d = {AFC_PAYLOAD, cc_q};
          end else if (pos_q == POS_PTR && (cur_kind == K_SYNC || data_pusi)) begin
            byte_d = 8'h00;
          end else if (cur_kind == K_SYNC) begin
            byte_d = sync_b;
          end else if (data_slot && !frame_done_q) begin
            byte_d = q_h[7:0];
            have   = q_v;
          end
        end
        default: begin
          byte_d = STUFF_BYTE;
        end
      endcase
    end
  end

  // Queue pops follow the emitted bytes, except passthrough bytes without a start flag, dropped at a packet start
  wire step     = adv && have;
  wire data_pop = step && cur_kind == K_DATA && pos_q != 8'h00 && data_slot
                  && !frame_done_q && !(pos_q == POS_PTR && data_pusi);
  assign pt_pop = (step && cur_kind == K_PT) || (at_start && pt_skip);
  assign hi_pop = data_pop && !sel_lo;
  assign lo_pop = data_pop && sel_lo;

  // Output byte register and packet position
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rf_valid <= 1'b0;
      rf_data  <= '0;
      rf_sop   <= 1'b0;
      pos_q    <= '0;
      kind_q   <= K_NULL;
    end else if (adv) begin
      rf_valid <= have;
      rf_data  <= byte_d;
      rf_sop   <= at_start;
      if (have) begin
        pos_q  <= pos_q == PKT_LAST ? 8'h00 : 8'(pos_q + 8'h01);
        kind_q <= cur_kind;
      end
    end
  end

  // Frame tracking across packets; a frame ending early stuffs the rest
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mid_frame_q  <= 1'b0;
      frame_done_q <= 1'b0;
      sel_lo_q     <= 1'b0;
      cc_q         <= '0;
    end else begin
      if (step && at_start) begin
        frame_done_q <= 1'b0;
        sel_lo_q     <= sel_lo;
      end
      if (step && pos_q == POS_CC && kind_q != K_NULL && kind_q != K_PT) begin
        cc_q <= cc_q + 4'h1;
      end
      if (data_pop) begin
        mid_frame_q  <= !q_h[8];
        frame_done_q <= q_h[8];
      end
    end
  end

  // Passthrough inspection, timestamp capture and header check sequence
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pt_pusi_q    <= 1'b0;
      pt_b4_zero_q <= 1'b0;
      pt_sync_q    <= 1'b0;
      ts_hold_q    <= '0;
      crc_q        <= CRC_INIT;
    end else if (step) begin
      if (pos_q == POS_PID_HI) begin
        pt_pusi_q <= cur_kind == K_PT ? pt_head[6] : data_pusi;
      end
      if (pos_q == POS_PTR) begin
        pt_b4_zero_q <= pt_head[7:0] == PT_SYNC_B4;
      end
      if (at_start) begin
        pt_sync_q <= 1'b0;
      end else if (pos_q == POS_MSG) begin
        pt_sync_q <= cur_kind == K_PT && pt_sync_now;
        ts_hold_q <= ts_q;
      end
      if (pos_q == POS_MSG) begin
        crc_q <= crc_byte(CRC_INIT, byte_d);
      end else if (pos_q > POS_MSG && pos_q <= POS_HDR_END) begin
        crc_q <= crc_byte(crc_q, byte_d);
      end
    end
  end

  // Ticks since the last inserted sync, saturating
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      elapsed_q <= '0;
    end else if (step && at_start && cur_kind == K_SYNC) begin
      elapsed_q <= '0;
    end else if (tb_tick && elapsed_q != 16'hffff) begin
      elapsed_q <= elapsed_q + 16'h1;
    end
  end

endmodule

// *** shared/dtd_pkg.sv ***
package dtd_pkg;

  // Clock rates used by the timebase divider, plus timestamp width and lag limit
  localparam int MCLK_KHZ = 250000;
  localparam int TB_KHZ   = 10240;
  localparam int TS_W     = 32;
  localparam int TS_LAG_MAX_TICKS = 100;

  // MPEG packet layout
  localparam logic [7:0]  PKT_LAST    = 8'hbb;
  localparam logic [7:0]  POS_PID_HI  = 8'h01;
  localparam logic [7:0]  POS_PID_LO  = 8'h02;
  localparam logic [7:0]  POS_CC      = 8'h03;
  localparam logic [7:0]  POS_PTR     = 8'h04;
  localparam logic [7:0]  POS_MSG     = 8'h05;
  localparam logic [7:0]  POS_HDR_END = 8'h08;
  localparam logic [7:0]  POS_HCS0    = 8'h09;
  localparam logic [7:0]  POS_HCS1    = 8'h0a;
  localparam logic [7:0]  POS_DA      = 8'h0b;
  localparam logic [7:0]  POS_SA      = 8'h11;
  localparam logic [7:0]  POS_MLEN    = 8'h17;
  localparam logic [7:0]  POS_DEST_ACCESS_POINT    = 8'h19;
  localparam logic [7:0]  POS_TS      = 8'h1f;
  localparam logic [7:0]  POS_MSG_END = 8'h22;
  localparam logic [7:0]  TS_BYTE     = 8'h47;
  localparam logic [7:0]  STUFF_BYTE  = 8'hff;
  localparam logic [12:0] PID_MAC     = 13'h1ffe;
  localparam logic [12:0] PID_NULL    = 13'h1fff;
  localparam logic [3:0]  AFC_PAYLOAD = 4'h1;

  // Sync message fields
  localparam logic [1:0]  FRAME_CONTROL_TYPE_MAC     = 2'h3;
  localparam logic [4:0]  FRAME_CONTROL_PARAMETER_TIMING  = 5'h00;
  localparam logic [7:0]  SYNC_MAC_PARM   = 8'h00;
  localparam logic [15:0] SYNC_MAC_LEN    = 16'h0018;
  localparam logic [47:0] SYNC_DA         = 48'h01e02f000001;
  localparam logic [15:0] SYNC_MSG_LEN    = 16'h000a;
  localparam logic [7:0]  NULL_SAP        = 8'h00;
  localparam logic [7:0]  LLC_UI          = 8'h03;
  localparam logic [7:0]  SYNC_VERSION    = 8'h01;
  localparam logic [7:0]  SYNC_TYPE       = 8'h01;
  localparam logic [7:0]  SYNC_RSVD       = 8'h00;
  localparam logic [7:0]  PT_SYNC_B4      = 8'h00;
  localparam logic [7:0]  PT_SYNC_B5      = 8'hc0;
  localparam logic [15:0] CRC_INIT        = 16'hffff;
  localparam logic [15:0] CRC_POLY        = 16'h8408;

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_PT   = 2'b01,
    MODE_PS   = 2'b10
  } dtd_mode_t;

  typedef enum logic [1:0] {
    K_NULL = 2'b00,
    K_PT   = 2'b01,
    K_SYNC = 2'b10,
    K_DATA = 2'b11
  } dtd_kind_t;

endpackage

// *** testbench/dtd_datapath_monitor.sv ***
module dtd_datapath_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // Session setup
  input wire logic        setup_req,
  input wire logic        setup_has_pt,
  input wire logic        setup_has_ps,
  input wire logic [3:0]  setup_levels,
  input wire logic [5:0]  setup_dscp_hi,
  input wire logic [5:0]  setup_dscp_lo,
  input wire logic        setup_accept,
  input wire logic        setup_reject,
  input wire logic [1:0]  session_mode,
  // Timebase
  input wire logic        ts_load,
  input wire logic [31:0] ts_load_value,
  input wire logic [31:0] ts_now,
  // RF byte stream
  input wire logic        rf_ready,
  input wire logic        rf_valid,
  input wire logic [7:0]  rf_data,
  input wire logic        rf_sop
);
  timeunit 1ns;
  timeprecision 1ps;
  // A tick is 250/10.24 mclk cycles, so no more than 25 cycles pass between steps
  localparam int TICK_GAP = 25;
  logic [31:0] ts_q;
  logic [7:0]  gap_q;
  logic [7:0]  cnt_q;
  logic        take;

  assign take = rf_valid && rf_ready;

  // Gap since the last timestamp step and bytes taken since the last packet start
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ts_q  <= 32'h0;
      gap_q <= 8'h0;
      cnt_q <= 8'h0;
    end else begin
      ts_q  <= ts_now;
      gap_q <= (ts_now != ts_q) ? 8'h0 : gap_q + 8'h1;
      cnt_q <= !take ? cnt_q : (rf_sop ? 8'h1 : cnt_q + 8'h1);
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_answer; setup_req |=> setup_accept != setup_reject; endproperty
  a_answer: assert property (p_answer) else $error("setup without one answer");
  property p_mixed; setup_req && setup_has_pt && setup_has_ps |=> setup_reject; endproperty
  a_mixed: assert property (p_mixed) else $error("mixed session not refused");
  property p_dscp;
    setup_req && setup_has_ps && setup_dscp_hi == setup_dscp_lo |=> !setup_accept;
  endproperty
  a_dscp: assert property (p_dscp) else $error("equal level codes accepted");
  property p_keep; setup_reject |-> $stable(session_mode); endproperty
  a_keep: assert property (p_keep) else $error("refusal changed the session");
  property p_mode; setup_accept |-> session_mode == ($past(setup_has_pt) ? 2'h1 : 2'h2); endproperty
  a_mode: assert property (p_mode) else $error("accepted session has wrong mode");
  property p_step;
    !$past(ts_load) && ts_now != $past(ts_now) |-> ts_now == $past(ts_now) + 32'h1;
  endproperty
  a_step: assert property (p_step) else $error("timestamp did not step by one");
  property p_load; ts_load |=> ts_now == $past(ts_load_value); endproperty
  a_load: assert property (p_load) else $error("timestamp load not applied");
  property p_tick; gap_q <= TICK_GAP; endproperty
  a_tick: assert property (p_tick) else $error("timestamp stalled");
  property p_hold;
    rf_valid && !rf_ready |=> rf_valid && $stable(rf_data) && $stable(rf_sop);
  endproperty
  a_hold: assert property (p_hold) else $error("RF byte dropped while stalled");
  property p_sync_byte; rf_valid && rf_sop |-> rf_data == 8'h47; endproperty
  a_sync_byte: assert property (p_sync_byte) else $error("packet start byte wrong");
  property p_len; take && rf_sop && cnt_q != 8'h0 |-> cnt_q == 8'hbc; endproperty
  a_len: assert property (p_len) else $error("packet not 188 bytes");
endmodule

bind dtd_datapath dtd_datapath_monitor dtd_datapath_monitor_inst (
  .mclk, .nrst, .setup_req, .setup_has_pt, .setup_has_ps, .setup_levels,
  .setup_dscp_hi, .setup_dscp_lo, .setup_accept, .setup_reject, .session_mode,
  .ts_load, .ts_load_value, .ts_now, .rf_ready, .rf_valid, .rf_data, .rf_sop
);

// *** testbench/dtd_core_model.sv ***
module dtd_core_model (
  // Clock
  input  wire logic mclk,
  // Passthrough bytes
  output logic       pt_valid,
  output logic [7:0] pt_data,
  output logic       pt_sop,
  input  wire logic  pt_ready,
  // Packet-stream bytes, low then higher latency
  output logic       ps_hi_valid,
  output logic [7:0] ps_hi_data,
  output logic       ps_hi_last,
  input  wire logic  ps_hi_ready,
  output logic       ps_lo_valid,
  output logic [7:0] ps_lo_data,
  output logic       ps_lo_last,
  input  wire logic  ps_lo_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  initial {pt_valid, pt_data, pt_sop, ps_hi_valid, ps_hi_data, ps_hi_last} = '0;
  initial {ps_lo_valid, ps_lo_data, ps_lo_last} = '0;

  // Passthrough packets are 188 bytes with 0x00 in byte 4 and the base in byte 5, a sync pattern only when the base is 0xc0
  function automatic logic [7:0] byte_of(input int sel, input int i, input logic [7:0] base);
    if (sel != 0) return base + 8'(i);
    case (i)
      0: return 8'h47;
      1: return 8'h5f;
      2: return 8'hfe;
      3: return 8'h10;
      4: return 8'h00;
      5: return base;
      default: return 8'(i) ^ 8'h5a;
    endcase
  endfunction

  task automatic put(input int sel, input logic v, input logic [7:0] d, input logic s);
    case (sel)
      0: {pt_valid, pt_data, pt_sop} = {v, d, s};
      1: {ps_hi_valid, ps_hi_data, ps_hi_last} = {v, d, s};
      default: {ps_lo_valid, ps_lo_data, ps_lo_last} = {v, d, s};
    endcase
  endtask

  // Holds each byte until ready is seen at a rising edge; released data is inverted
  task automatic send(input int sel, input int len, input logic [7:0] base);
    int i;
    logic [7:0] d;
    for (i = 0; i < len; i++) begin
      d = byte_of(sel, i, base);
      @(negedge mclk);
      put(sel, 1'b1, d, (sel == 0) ? (i == 0) : (i == len - 1));
      do @(posedge mclk); while (!(sel == 0 ? pt_ready : sel == 1 ? ps_hi_ready : ps_lo_ready));
    end
    @(negedge mclk);
    put(sel, 1'b0, ~d, 1'b0);
  endtask
endmodule

// *** testbench/dtd_datapath_test.sv ***
module dtd_datapath_test;
  import dtd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic pt; logic ps; logic [3:0] lv; logic [3:0] fl;
    logic [5:0] dh; logic [5:0] dl; logic acc; logic [1:0] md;
  } dtd_row_t;
  logic mclk = 0, nrst = 0, setup_req = 0, setup_has_pt = 0, setup_has_ps = 0;
  logic [3:0] setup_levels = 0, setup_flows = 0;
  logic [5:0] setup_dscp_hi = 0, setup_dscp_lo = 0;
  logic [15:0] setup_sync_interval = 16'hffff;
  logic [47:0] setup_core_mac = 48'h020000a1b2c3;
  logic ts_load = 0, rf_ready = 1, setup_accept, setup_reject, pt_ready, ps_hi_ready;
  logic [31:0] ts_load_value = 0, ts_now, ts5, ts_prev;
  logic [1:0] session_mode;
  logic pt_valid, pt_sop, ps_hi_valid, ps_hi_last, ps_lo_valid, ps_lo_last, ps_lo_ready;
  logic rf_valid, rf_sop;
  logic [7:0] pt_data, ps_hi_data, ps_lo_data, rf_data, cc;
  logic [7:0] pk [188];
  logic [247:0] ev;
  int checked, bad_count, cyc, i, k, n;
  // Refused rows carry the mode that must survive them
  dtd_row_t rows [9] = '{'{1,0,1,1,0,0,1,1}, '{1,1,1,1,1,2,0,1}, '{1,0,2,1,0,0,0,1},
    '{0,1,2,1,5,9,1,2}, '{0,1,1,1,5,9,0,2}, '{0,1,2,1,7,7,0,2}, '{0,1,2,0,5,9,0,2},
    '{0,1,2,2,5,9,0,2}, '{0,1,3,1,5,9,0,2}};

  always #2 mclk = ~mclk;

  dtd_datapath dtd_datapath_inst (.*);
  dtd_core_model dtd_core_model_inst (.*);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask

  task automatic setup(input dtd_row_t r, input logic [15:0] ivl);
    @(negedge mclk);
    {setup_req, setup_has_pt, setup_has_ps, setup_levels, setup_flows} = {1'b1, r.pt, r.ps, r.lv, r.fl};
    {setup_dscp_hi, setup_dscp_lo, setup_sync_interval} = {r.dh, r.dl, ivl};
    @(negedge mclk);
    setup_req = 1'b0;
    chk("setup_accept", r.acc, setup_accept);
    chk("session_mode", r.md, session_mode);
  endtask

  // Collects one packet from its start byte; ts5 is the count when byte 5 was registered
  task automatic get_pkt;
    i = 0;
    n = 0;
    while (i < 188 && n < 3000) begin
      @(posedge mclk);
      n++;
      if (rf_valid && rf_ready && (rf_sop || i > 0)) begin
        if (i == 5) ts5 = ts_prev;
        pk[i] = rf_data;
        i++;
      end
      ts_prev = ts_now;
    end
    chk("pkt_len", 188, i);
  endtask

  // Skips null packets, which are the only ones with 0xff in byte 2
  task automatic get_data;
    get_pkt;
    for (k = 0; k < 8 && pk[2] == 8'hff; k++) get_pkt;
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Ceiling well above the few thousand cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim;
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    chk("mode_in_reset", 0, session_mode);
    chk("pt_ready_in_reset", 1, pt_ready);
    @(negedge mclk) nrst = 1'b1;
    get_pkt;
    for (int j = 0; j < 188; j++)
      chk("null", j == 0 ? 8'h47 : j == 1 ? 8'h1f : j == 3 ? 8'h10 : 8'hff, pk[j]);
    @(negedge mclk) {ts_load, ts_load_value} = {1'b1, 32'hffffffff};
    @(negedge mclk) ts_load = 1'b0;
    chk("ts_load", 32'hffffffff, ts_now);
    for (n = 0; n < 40 && ts_now !== 0; n++) @(negedge mclk);
    chk("ts_wrap", 0, ts_now);
    foreach (rows[r]) setup(rows[r], 16'hffff);
    // A 20-byte frame against a stalled output must fill the receiver
    @(negedge mclk) rf_ready = 1'b0;
    fork dtd_core_model_inst.send(1, 20, 8'h30); join_none
    for (n = 0; n < 60 && ps_hi_ready; n++) @(negedge mclk);
    chk("hi_refuses", 0, ps_hi_ready);
    @(negedge mclk) rf_ready = 1'b1;
    get_data;
    wait fork;
    for (int j = 0; j < 188; j++)
      chk("frame", j == 1 ? 8'h5f : j == 2 ? 8'hfe : j == 4 ? 8'h00 :
          (j > 4 && j < 25) ? 8'(8'h2b + j) : pk[j], pk[j]);
    for (int j = 25; j < 188; j++) chk("stuffing", 8'hff, pk[j]);
    // Lower level queued first; the higher level must still leave first
    @(negedge mclk) rf_ready = 1'b0;
    dtd_core_model_inst.send(2, 6, 8'h60);
    dtd_core_model_inst.send(1, 6, 8'h90);
    @(negedge mclk) rf_ready = 1'b1;
    get_data;
    cc = pk[3];
    for (int j = 0; j < 6; j++) chk("first_frame", 8'(8'h90 + j), pk[5 + j]);
    get_data;
    for (int j = 0; j < 6; j++) chk("second_frame", 8'(8'h60 + j), pk[5 + j]);
    chk("continuity", {cc[7:4], cc[3:0] + 4'h1}, pk[3]);
    setup('{0,1,2,1,5,9,1,2}, 16'h0020);
    get_data;
    ev = {16'h00c0, 24'h000018, 16'h0, SYNC_DA, setup_core_mac, 64'h000a000003010100, ts5};
    chk("sync_start", 8'h5f, pk[1]);
    for (int j = 4; j < 35; j++)
      if (j != 9 && j != 10) chk("sync", ev[8 * (34 - j) +: 8], pk[j]);
    setup('{1,0,1,1,0,0,1,1}, 16'hffff);
    fork
      begin
        dtd_core_model_inst.send(0, 188, 8'hc0);
        dtd_core_model_inst.send(0, 188, 8'hc1);
      end
    join_none
    for (int p = 0; p < 2; p++) begin
      get_data;
      for (int j = 0; j < 188; j++)
        chk("passthrough", (p == 0 && j > 30 && j < 35) ? ts5[8 * (34 - j) +: 8] :
            dtd_core_model_inst.byte_of(0, j, p == 0 ? 8'hc0 : 8'hc1), pk[j]);
    end
    wait fork;
    @(negedge mclk) nrst = 1'b0;
    @(negedge mclk) chk("mode_after_reset", 0, session_mode);
    nrst = 1'b1;
    end_sim;
  end
endmodule
